// ---- rtl/lsd_defs.svh ----
// Behaviour
// - Enable bit 7 gates common-mode balance interrupt
// - Enable bits 5:0 gate power alarms Q6..Q1
// - Loopback bit 7 loops codec; resets zero
// - Detect bit 5 shows common-mode high, read-only
// - Detect bit 4 shows speedup setting
// - Detect bit 3 shows open-voltage tracking active
// - Detect bit 2 shows ground key live
// - Detect bit 1 shows ring trip live
// - Detect bit 0 shows loop closure live
// - Detect flags live; history only in pending
// - Command bits 2:0 select driven line state
// - Eight line states with fixed three-bit codes
// - Shadow bits 6:4 show real-time line state
// - Ringing command: shadow alternates ringing and ON_HOOK_TRANSMISSION
// - Pending bits at register 17, enable positions
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH
`define LSD_ADDR_LINE_STATE      8'h06
`define LSD_ADDR_DETECT          8'h09
`define LSD_ADDR_ALARM_PENDING   8'h11
`define LSD_ADDR_ALARM_ENABLE    8'h14
`define LSD_ADDR_LOOPBACK        8'h16
`define LSD_BIT_CMBAL            7
`define LSD_BIT_LOOPBACK         7
`define LSD_BIT_CMH              5
`define LSD_BIT_SPEED            4
`define LSD_BIT_VOCTRK           3
`define LSD_BIT_GNDKEY           2
`define LSD_BIT_RTRIP            1
`define LSD_BIT_LOOP             0
`define LSD_ALARM_MASK           8'hBF
`define LSD_RESET_LOOPBACK       8'h00
`define LSD_RESET_ENABLE         8'h00
`define LSD_RESET_CMD            3'h0
`define LSD_SYNC_STAGES          2
`endif

// ---- rtl/lsd_pkg.sv ----
package lsd_pkg;
   // Line state codes, shared by command and shadow fields
   typedef enum logic [2:0] {
      LSD_OPEN         = 3'h0,
      LSD_FWD_ACTIVE   = 3'h1,
      LSD_FWD_OHT      = 3'h2,
      LSD_TIP_OPEN     = 3'h3,
      LSD_RINGING      = 3'h4,
      LSD_REV_ACTIVE   = 3'h5,
      LSD_REV_OHT      = 3'h6,
      LSD_RING_OPEN    = 3'h7
   } lsd_line_state_type;

   // Live analog detector levels, asynchronous to clk
   typedef struct packed {
      logic       common_mode_high;
      logic       speedup;
      logic       open_voltage_tracking;
      logic       ground_key;
      logic       ring_trip;
      logic       loop_closure;
   } lsd_detect_type;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } lsd_bus_req_type;
endpackage : lsd_pkg

// ---- rtl/lsd_regs.sv ----
`timescale 1ns/1ps
`include "lsd_defs.svh"
// Per-channel line detect, alarm mask, loopback and linefeed registers
module lsd_regs (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire lsd_pkg::lsd_bus_req_type    bus_req,
   output logic [7:0]                       rdata,
   input  wire lsd_pkg::lsd_detect_type     detect_async,
   input  wire logic                        cm_balance_event,
   input  wire logic [5:0]                  power_alarm_event,
   input  wire logic                        ring_burst,
   input  wire logic                        auto_override,
   input  wire lsd_pkg::lsd_line_state_type auto_state,
   output lsd_pkg::lsd_line_state_type      line_state_command,
   output lsd_pkg::lsd_line_state_type      line_state_shadow,
   output logic                             codec_loopback_enable,
   output logic                             alarm_irq
);
   import lsd_pkg::*;

   lsd_detect_type      detect;
   logic [7:0]          alarm_irq_enable;
   logic [7:0]          alarm_irq_pending;
   logic [7:0]          loopback_control;
   logic [7:0]          alarm_events;
   logic [7:0]          next_pending;
   logic [7:0]          next_rdata;
   logic [7:0]          detect_byte;
   logic [7:0]          line_state_byte;
   logic                hit_line_state;
   logic                hit_detect;
   logic                hit_pending;
   logic                hit_enable;
   logic                hit_loopback;
   logic                wr_line_state;
   logic                wr_pending;
   logic                wr_enable;
   logic                wr_loopback;
   logic                next_irq;

   // Detector levels come off the analog side, so synchronise first
   lsd_sync #(
      .WIDTH ($bits(lsd_detect_type))
   ) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in (detect_async),
      .sync_out (detect)
   );

   // Shadow state tracker
   lsd_state u_state (
      .clk           (clk),
      .resetn        (resetn),
      .command       (line_state_command),
      .ring_burst    (ring_burst),
      .auto_override (auto_override),
      .auto_state    (auto_state),
      .shadow        (line_state_shadow)
   );

   // Address decode
   assign hit_line_state = bus_req.addr == `LSD_ADDR_LINE_STATE;
   assign hit_detect     = bus_req.addr == `LSD_ADDR_DETECT;
   assign hit_pending    = bus_req.addr == `LSD_ADDR_ALARM_PENDING;
   assign hit_enable     = bus_req.addr == `LSD_ADDR_ALARM_ENABLE;
   assign hit_loopback   = bus_req.addr == `LSD_ADDR_LOOPBACK;
   assign wr_line_state  = bus_req.wr && hit_line_state;
   assign wr_pending     = bus_req.wr && hit_pending;
   assign wr_enable      = bus_req.wr && hit_enable;
   assign wr_loopback    = bus_req.wr && hit_loopback;

   // Detect flags are the live levels, never latched
   assign detect_byte = {2'b00,
                         detect.common_mode_high,
                         detect.speedup,
                         detect.open_voltage_tracking,
                         detect.ground_key,
                         detect.ring_trip,
                         detect.loop_closure};

   assign line_state_byte = {1'b0, line_state_shadow, 1'b0, line_state_command};

   // Events land at their enable bit positions; bit 6 stays reserved
   assign alarm_events = {cm_balance_event, 1'b0, power_alarm_event};

   // Write one clears, but a new event in the same cycle wins
   assign next_pending = ((alarm_irq_pending & ~(wr_pending ? bus_req.wdata : 8'h00))
                          | alarm_events) & `LSD_ALARM_MASK;

   // Mask gates the request only; pending history is untouched
   assign next_irq = |(next_pending & alarm_irq_enable);

   // Read mux; unmapped addresses read zero
   assign next_rdata = hit_line_state ? line_state_byte   :
                       hit_detect     ? detect_byte       :
                       hit_pending    ? alarm_irq_pending :
                       hit_enable     ? alarm_irq_enable  :
                       hit_loopback   ? loopback_control  : 8'h00;

   assign codec_loopback_enable = loopback_control[`LSD_BIT_LOOPBACK];

   // Writable registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         line_state_command <= lsd_line_state_type'(`LSD_RESET_CMD);
         alarm_irq_enable   <= `LSD_RESET_ENABLE;
         loopback_control   <= `LSD_RESET_LOOPBACK;
      end else begin
         if (wr_line_state) line_state_command <= lsd_line_state_type'(bus_req.wdata[2:0]);
         if (wr_enable)     alarm_irq_enable   <= bus_req.wdata & `LSD_ALARM_MASK;
         if (wr_loopback)   loopback_control   <= bus_req.wdata & 8'h80;
      end
   end

   // Pending bits, interrupt line and read data
   always_ff @(posedge clk) begin
      if (!resetn) begin
         alarm_irq_pending <= 8'h00;
         alarm_irq         <= 1'b0;
         rdata             <= 8'h00;
      end else begin
         alarm_irq_pending <= next_pending;
         alarm_irq         <= next_irq;
         rdata             <= bus_req.rd ? next_rdata : 8'h00;
      end
   end
endmodule : lsd_regs

// ---- rtl/lsd_state.sv ----
`timescale 1ns/1ps
`include "lsd_defs.svh"
// Real-time line state tracker; ring cadence comes from the ring generator
module lsd_state (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire lsd_pkg::lsd_line_state_type command,
   input  wire logic                        ring_burst,
   input  wire logic                        auto_override,
   input  wire lsd_pkg::lsd_line_state_type auto_state,
   output lsd_pkg::lsd_line_state_type      shadow
);
   import lsd_pkg::*;

   lsd_line_state_type next_shadow;

   // Automatic operations win over the command; ringing follows bursts
   always_comb begin
      if (auto_override) begin
         next_shadow = auto_state;
      end else begin
         case (command)
            LSD_RINGING:    next_shadow = ring_burst ? LSD_RINGING : LSD_FWD_OHT;
            LSD_OPEN,
            LSD_FWD_ACTIVE,
            LSD_FWD_OHT,
            LSD_TIP_OPEN,
            LSD_REV_ACTIVE,
            LSD_REV_OHT,
            LSD_RING_OPEN:  next_shadow = command;
            default:        next_shadow = LSD_OPEN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) shadow <= LSD_OPEN;
      else         shadow <= next_shadow;
   end
endmodule : lsd_state

// ---- rtl/lsd_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser, one per bit; first stage read only by second
module lsd_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!resetn) begin
               stage1[i]   <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               stage1[i]   <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule : lsd_sync

// ---- tb/lsd_regs_assertions.sv ----
`timescale 1ns/1ps
// Port-level checks of the line state and alarm register block
module lsd_regs_assertions (
   input wire logic                        clk,
   input wire logic                        resetn,
   input wire lsd_pkg::lsd_bus_req_type    bus_req,
   input wire logic                        cm_balance_event,
   input wire logic [5:0]                  power_alarm_event,
   input wire logic                        ring_burst,
   input wire logic                        auto_override,
   input wire lsd_pkg::lsd_line_state_type auto_state,
   input wire lsd_pkg::lsd_line_state_type line_state_command,
   input wire lsd_pkg::lsd_line_state_type line_state_shadow,
   input wire logic                        codec_loopback_enable,
   input wire logic                        alarm_irq
);
   import lsd_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // A write to one address, and ringing commanded without override
   sequence s_wr(logic [7:0] a);
      bus_req.wr && bus_req.addr == a;
   endsequence
   sequence s_ring;
      line_state_command == LSD_RINGING && !auto_override;
   endsequence
   // Writes land one edge later; nothing else moves the command
   a_loop_write: assert property (s_wr(8'h16) |=> codec_loopback_enable == $past(bus_req.wdata[7]))
      else $error("loopback missed write");
   a_cmd_write: assert property (s_wr(8'h06) |=> line_state_command == $past(bus_req.wdata[2:0]))
      else $error("command missed write");
   a_cmd_hold: assert property (!(bus_req.wr && bus_req.addr == 8'h06) |=> $stable(line_state_command))
      else $error("command moved alone");
   // Shadow follows the command one cycle late, ringing splits by burst
   a_shadow_track: assert property (
      !auto_override && line_state_command != LSD_RINGING |=> line_state_shadow == $past(line_state_command))
      else $error("shadow off command");
   a_ring_burst: assert property (s_ring ##0 ring_burst |=> line_state_shadow == LSD_RINGING)
      else $error("shadow not ringing");
   a_ring_silent: assert property (s_ring ##0 !ring_burst |=> line_state_shadow == LSD_FWD_OHT)
      else $error("shadow not silent");
   // Automatic operations take the shadow regardless of the command
   a_auto_follow: assert property (auto_override |=> line_state_shadow == $past(auto_state))
      else $error("shadow missed auto state");
   // The request only moves after an event or a register write
   a_irq_rise: assert property ($rose(alarm_irq) |->
      $past(cm_balance_event || (|power_alarm_event)) || $past(bus_req.wr) || $past(bus_req.wr, 2))
      else $error("irq rose alone");
   a_irq_fall: assert property ($fell(alarm_irq) |-> $past(bus_req.wr) || $past(bus_req.wr, 2))
      else $error("irq fell alone");
endmodule : lsd_regs_assertions

bind lsd_regs lsd_regs_assertions u_chk (.clk(clk), .resetn(resetn), .bus_req(bus_req),
   .cm_balance_event(cm_balance_event), .power_alarm_event(power_alarm_event), .ring_burst(ring_burst),
   .auto_override(auto_override), .auto_state(auto_state), .line_state_command(line_state_command),
   .line_state_shadow(line_state_shadow), .codec_loopback_enable(codec_loopback_enable), .alarm_irq(alarm_irq));

// ---- tb/lsd_regs_tb.sv ----
`timescale 1ns/1ps
// Bench for the line state and alarm registers; reads are checked from a queue of notes
module lsd_regs_tb;
   import lsd_pkg::*;
   logic            clk = 1'b0, resetn = 1'b0, rd_seen = 1'b0, cm_ev = 1'b0, burst = 1'b0, loop_en, irq;
   logic [5:0]      pa_ev = 6'h00;
   logic [7:0]      rdata, exp_q[$];
   logic [31:0]     r, m;
   lsd_bus_req_type req = '0;
   lsd_detect_type  det = '0;
   lsd_line_state_type cmd, shd, ast = LSD_OPEN;
   logic            ovr = 1'b0;
   integer          seed = 36982, err_total = 0, comparisons = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Automatic override is driven too, so the shadow can part from the command
   lsd_regs dut (.clk(clk), .resetn(resetn), .bus_req(req), .rdata(rdata), .detect_async(det),
      .cm_balance_event(cm_ev), .power_alarm_event(pa_ev), .ring_burst(burst), .auto_override(ovr),
      .auto_state(ast), .line_state_command(cmd), .line_state_shadow(shd), .codec_loopback_enable(loop_en),
      .alarm_irq(irq));

   // Count one comparison and report a difference at once
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Request held for n edges; a read notes its expected byte, so reads use n of 1
   task op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic rr, input logic [7:0] e, input int n);
      if (rr)
         exp_q.push_back(e);
      req <= {a, d, w, rr};
      repeat (n) @(posedge clk);
   endtask : op

   task idle(input int n);
      op(8'h00, 8'h00, 1'b0, 1'b0, 8'h00, n);
   endtask : idle

   task final_report;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // Read data stands one cycle after the strobe; take the oldest note then
   always @(posedge clk) begin
      if (rd_seen)
         chk(rdata, exp_q.pop_front());
      rd_seen <= req.rd;
   end

   // The sequence needs under 500 cycles
   initial begin
      repeat (4000) @(posedge clk);
      err_total++;
      final_report;
   end

   // Reset, register traffic with detector levels, line states, then alarms
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      op(8'h16, 8'h00, 1'b0, 1'b1, 8'h00, 1);
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         det <= r[5:0];
         op(8'h14, r[7:0], 1'b1, 1'b0, 8'h00, 1);
         op(8'h16, r[15:8], 1'b1, 1'b0, 8'h00, 1);
         op(8'h09, r[15:8], 1'b1, 1'b0, 8'h00, 1);
         op(8'h14, 8'h00, 1'b0, 1'b1, r[7:0] & 8'hBF, 1);
         op(8'h16, 8'h00, 1'b0, 1'b1, r[15:8] & 8'h80, 1);
         op(8'h30, 8'h00, 1'b0, 1'b1, 8'h00, 1);
         op(8'h09, 8'h00, 1'b0, 1'b1, {2'h0, r[5:0]}, 1);
         chk({7'h0, loop_en}, {7'h0, r[15]});
      end
      // Upper bits are junk on purpose: only the command field may take them
      for (int s = 0; s < 8; s++) begin
         r = $random(seed);
         op(8'h06, {r[4:0], 3'(s)}, 1'b1, 1'b0, 8'h00, 1);
         idle(3);
         op(8'h06, 8'h00, 1'b0, 1'b1, {1'b0, ((s == 4) ? 3'h2 : 3'(s)), 1'b0, 3'(s)}, 1);
         chk({5'h0, cmd}, {5'h0, 3'(s)});
         chk({5'h0, shd}, {5'h0, ((s == 4) ? 3'h2 : 3'(s))});
      end
      burst <= 1'b1;
      op(8'h06, 8'h04, 1'b1, 1'b0, 8'h00, 1);
      idle(3);
      op(8'h06, 8'h00, 1'b0, 1'b1, 8'h44, 1);
      burst <= 1'b0;
      // Automatic operations override the ringing command in the shadow
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         ovr <= 1'b1;
         ast <= lsd_line_state_type'(r[2:0]);
         idle(2);
         op(8'h06, 8'h00, 1'b0, 1'b1, {1'b0, r[2:0], 1'b0, 3'h4}, 1);
         chk({5'h0, shd}, {5'h0, r[2:0]});
      end
      ovr <= 1'b0;
      idle(2);
      op(8'h06, 8'h00, 1'b0, 1'b1, 8'h24, 1);
      // Each pending bit: raise masked, enable, mask again, then clear
      for (int b = 0; b < 7; b++) begin
         m = (b == 6) ? 32'h80 : 32'h1 << b;
         {cm_ev, pa_ev} <= {m[7], m[5:0]};
         op(8'h14, 8'h00, 1'b1, 1'b0, 8'h00, 1);
         {cm_ev, pa_ev} <= 7'h00;
         op(8'h14, m[7:0], 1'b1, 1'b0, 8'h00, 1);
         idle(3);
         chk({7'h0, irq}, 8'h01);
         op(8'h14, ~m[7:0], 1'b1, 1'b0, 8'h00, 1);
         op(8'h11, 8'h00, 1'b0, 1'b1, m[7:0], 1);
         idle(2);
         chk({7'h0, irq}, 8'h00);
         op(8'h11, m[7:0], 1'b1, 1'b0, 8'h00, 1);
         op(8'h11, 8'h00, 1'b0, 1'b1, 8'h00, 1);
      end
      // An event in the clearing cycle must win over the clear
      {cm_ev, pa_ev} <= 7'h7F;
      op(8'h11, 8'hFF, 1'b1, 1'b0, 8'h00, 1);
      {cm_ev, pa_ev} <= 7'h00;
      op(8'h11, 8'h00, 1'b0, 1'b1, 8'hBF, 1);
      op(8'h11, 8'hFF, 1'b1, 1'b0, 8'h00, 1);
      op(8'h11, 8'h00, 1'b0, 1'b1, 8'h00, 1);
      idle(3);
      chk(8'(exp_q.size()), 8'h00);
      final_report;
   end
endmodule : lsd_regs_tb
